// ### hdl/sed_pkg.sv
// constants, layouts and carrier types for the status and event dispatch block
package sed_pkg;

	// status longword layout
	localparam int          PSL_C        = 0;
	localparam int          PSL_V        = 1;
	localparam int          PSL_Z        = 2;
	localparam int          PSL_N        = 3;
	localparam int          PSL_EN_TRACE = 4;
	localparam int          PSL_EN_OVF   = 5;
	localparam int          PSL_EN_UNF   = 6;
	localparam int          PSL_IPL_LO   = 16;
	localparam int          PSL_PRV_LO   = 22;
	localparam int          PSL_CUR_LO   = 24;
	localparam int          PSL_SYSCTX   = 26;
	localparam logic [31:0] PSL_USER_MASK = 32'h0000_007f;
	localparam logic [31:0] PSL_PRIV_MASK = 32'h07df_0000;
	localparam logic [31:0] PSL_RESET     = 32'h001f_0000;

	localparam logic [1:0]  MODE_KERNEL = 2'h0;

	// pending exception bits, lowest index is served first
	localparam int          EXC_TRACE = 0;
	localparam int          EXC_OVF   = 1;
	localparam int          EXC_DVZ   = 2;
	localparam int          EXC_UNF   = 3;
	localparam int          EXC_PRIV  = 4;
	localparam int          EXC_W     = 5;

	localparam logic [7:0]  VEC_EXC_BASE = 8'h20;
	localparam logic [7:0]  VEC_INT_BASE = 8'h80;

	localparam int          IRQ_LINES = 16;

	// register byte offsets
	localparam logic [7:0]  A_PSL      = 8'h00;
	localparam logic [7:0]  A_STATUS   = 8'h04;
	localparam logic [7:0]  A_SLOT     = 8'h08;
	localparam logic [7:0]  A_FRAME    = 8'h0c;
	localparam logic [7:0]  A_SAVE_PC  = 8'h10;
	localparam logic [7:0]  A_SAVE_PSL = 8'h14;
	localparam logic [7:0]  A_CTRL     = 8'h18;
	localparam logic [7:0]  A_MAP0     = 8'h20;
	localparam int          STAT_REFUSED = 8;
	localparam int          CTRL_RESUME  = 0;

	// hardware context store
	localparam int          CTX_SLOTS = 8;
	localparam int          CTX_WORDS = 4;
	localparam int          CTX_PSL   = 0;
	localparam int          CTX_PC    = 1;
	localparam int          CTX_SP    = 2;
	localparam int          CTX_FP    = 3;

	localparam logic [31:0] FRAME_WORD  = 32'h0000_0004;
	localparam int          PAGE_BITS   = 9;
	localparam int          MAP_REGIONS = 4;

	typedef enum logic [3:0] {
		SED_K_SUB = 4'h1,
		SED_K_INT = 4'h2,
		SED_K_FLT = 4'h4,
		SED_K_DEC = 4'h8
	} sed_kind_t;

	typedef struct packed {
		sed_kind_t   kind;
		logic        is_div;
		logic [31:0] a;
		logic [31:0] b;
		logic [31:0] res;
		logic        fmt_ovf;
		logic        fmt_unf;
	} sed_op_t;

	typedef struct packed {
		logic        is_intr;
		logic [7:0]  vector;
		logic [4:0]  level;
		logic [31:0] saved_pc;
		logic [31:0] saved_psl;
	} sed_disp_t;

endpackage

// ### hdl/sed_prio_pick.sv
// picks the highest pending interrupt line and compares it to the current level
`timescale 1ns/10ps
module sed_prio_pick (
	input  wire logic [15:0] i_req,
	input  wire logic [4:0]  i_ipl,
	output logic             o_take,
	output logic [4:0]       o_level
);
	import sed_pkg::*;

	function automatic logic [4:0] highest(input logic [15:0] r);
		logic [4:0] h;
		h = 5'h00;
		for (int i = 1; i < IRQ_LINES; i++)
		begin
			if (r[i])
				h = 5'(i);
		end
		return h;
	endfunction

	// line 0 carries no priority, so level 0 means nothing pending
	always_comb
	begin
		o_level = highest(i_req);
		o_take  = (o_level != 5'h00) && (o_level > i_ipl);
	end

endmodule // sed_prio_pick

// ### hdl/sed_status_dispatch.sv
// status longword, exception and interrupt dispatch, context and frame logic
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/10ps
module sed_status_dispatch (
	input  wire logic               I_SYS_CLK,
	input  wire logic               I_RST_N,
	input  wire logic               I_CE,
	input  wire logic               I_WB_CYC,
	input  wire logic               I_WB_STB,
	input  wire logic               I_WB_WE,
	input  wire logic [7:0]         I_WB_ADR,
	input  wire logic [3:0]         I_WB_SEL,
	input  wire logic [31:0]        I_WB_DAT,
	output logic [31:0]             O_WB_DAT,
	output logic                    O_WB_ACK,
	input  wire logic               I_OP_VALID,
	input  wire sed_pkg::sed_op_t   I_OP,
	input  wire logic               I_INSN_BOUNDARY,
	input  wire logic               I_RESUME_POINT,
	input  wire logic [31:0]        I_PC,
	input  wire logic [31:0]        I_SP,
	input  wire logic [15:0]        I_IRQ_REQ,
	input  wire logic               I_HALT_REQ,
	input  wire logic               I_CTX_SAVE,
	input  wire logic               I_CTX_LOAD,
	input  wire logic               I_CALL,
	input  wire logic               I_RET,
	input  wire logic [31:0]        I_RET_FP,
	input  wire logic               I_VA_REQ,
	input  wire logic [31:0]        I_VA,
	output logic [31:0]             O_PSL,
	output logic                    O_DISP_VALID,
	output sed_pkg::sed_disp_t      O_DISP,
	output logic                    O_HALTED,
	output logic                    O_CTX_VALID,
	output logic [31:0]             O_CTX_PC,
	output logic [31:0]             O_CTX_SP,
	output logic [31:0]             O_FRAME_LINK_PTR,
	output logic                    O_FRAME_WR,
	output logic [31:0]             O_FRAME_ADDR,
	output logic [31:0]             O_FRAME_DATA,
	output logic                    O_RESUME_VALID,
	output logic [31:0]             O_RESUME_PC,
	output logic                    O_BUS_REQ,
	output logic [31:0]             O_BUS_ADDR,
	output logic                    O_TB_HIT
);
	import sed_pkg::*;

	logic [31:0]     psl_r;
	logic [31:0]     psl_nxt;
	logic [EXC_W-1:0] exc_pend_r;
	logic [EXC_W-1:0] exc_new;
	logic [EXC_W-1:0] exc_clr;
	logic            refused_r;
	logic [2:0]      slot_r;
	logic [31:0]     fp_r;
	logic [31:0]     save_pc_r;
	logic [31:0]     save_psl_r;
	logic [31:0]     map_r [MAP_REGIONS];
	logic [31:0]     ctx_mem [CTX_SLOTS][CTX_WORDS];
	logic [22:0]     tb_vpage_r;
	logic [22:0]     tb_ppage_r;
	logic            tb_valid_r;
	logic            wb_ack_r;
	logic [31:0]     wb_dat_r;
	logic            wb_wr;
	logic            priv_ok;
	logic            irq_take;
	logic            exc_take;
	logic            pick_take;
	logic [4:0]      pick_level;
	logic            rei_req;
	logic            rei_ok;
	logic            ctx_load_ok;
	logic            ctx_save_ok;
	logic [32:0]     sub_full;
	logic            ovf_det;
	logic            bus_priv_wr;
	logic [31:0]     tb_pa;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++)
		begin
			if (sel[i])
				m[8*i +: 8] = nw[8*i +: 8];
		end
		return m;
	endfunction

	function automatic logic [2:0] first_set(input logic [EXC_W-1:0] p);
		logic [2:0] f;
		f = 3'h0;
		for (int i = EXC_W - 1; i >= 0; i--)
		begin
			if (p[i])
				f = 3'(i);
		end
		return f;
	endfunction

	sed_prio_pick u_pick (
		.i_req   (I_IRQ_REQ),
		.i_ipl   (psl_r[PSL_IPL_LO +: 5]),
		.o_take  (pick_take),
		.o_level (pick_level)
	);

	// a write lands on the edge where the master sees ack high
	assign wb_wr       = I_WB_CYC & I_WB_STB & I_WB_WE & wb_ack_r;
	assign priv_ok     = psl_r[PSL_CUR_LO +: 2] == MODE_KERNEL;
	assign bus_priv_wr = wb_wr && (I_WB_ADR == A_SLOT || I_WB_ADR == A_CTRL
		|| I_WB_ADR[7:4] == A_MAP0[7:4]);
	assign rei_req     = wb_wr && I_WB_ADR == A_CTRL && I_WB_SEL[0] && I_WB_DAT[CTRL_RESUME];
	// resume may only keep or lower privilege
	assign rei_ok      = rei_req && priv_ok
		&& save_psl_r[PSL_CUR_LO +: 2] >= psl_r[PSL_CUR_LO +: 2];
	assign ctx_save_ok = I_CTX_SAVE & priv_ok;
	assign ctx_load_ok = I_CTX_LOAD & priv_ok;

	// interrupts come from their own pick path and win the cycle
	assign irq_take = pick_take & (I_INSN_BOUNDARY | I_RESUME_POINT);
	assign exc_take = (exc_pend_r != '0) & ~irq_take;

	assign sub_full = {1'b0, I_OP.a} - {1'b0, I_OP.b};
	assign ovf_det  = (I_OP.kind == SED_K_SUB)
		? ((I_OP.a[31] ^ I_OP.b[31]) & (I_OP.a[31] ^ sub_full[31]))
		: I_OP.fmt_ovf;

	// synchronous exception detection from the current operation, the trace enable and privileged requests
	always_comb
	begin
		exc_new = '0;
		if (I_OP_VALID)
		begin
			exc_new[EXC_OVF] = ovf_det & psl_r[PSL_EN_OVF];
			exc_new[EXC_DVZ] = I_OP.is_div & (I_OP.b == 32'h0000_0000);
			exc_new[EXC_UNF] = (I_OP.kind == SED_K_FLT) & I_OP.fmt_unf
				& psl_r[PSL_EN_UNF];
		end
		exc_new[EXC_TRACE] = I_INSN_BOUNDARY & psl_r[PSL_EN_TRACE];
		exc_new[EXC_PRIV]  = ((I_HALT_REQ | I_CTX_SAVE | I_CTX_LOAD) & ~priv_ok)
			| (rei_req & ~rei_ok);
		exc_clr = '0;
		if (exc_take)
			exc_clr[first_set(exc_pend_r)] = 1'b1;
	end

	// next status longword; later steps override earlier ones
	always_comb
	begin
		psl_nxt = psl_r;
		if (I_OP_VALID)
		begin
			if (I_OP.kind == SED_K_SUB)
			begin
				psl_nxt[PSL_N] = sub_full[31];
				psl_nxt[PSL_Z] = sub_full[31:0] == 32'h0000_0000;
				psl_nxt[PSL_C] = sub_full[32];
			end
			else
			begin
				psl_nxt[PSL_N] = I_OP.res[31];
				psl_nxt[PSL_Z] = I_OP.res == 32'h0000_0000;
				psl_nxt[PSL_C] = 1'b0;
			end
			psl_nxt[PSL_V] = ovf_det;
		end
		if (wb_wr && I_WB_ADR == A_PSL)
		begin
			// user half is open to all, privileged half only in kernel
			psl_nxt = (psl_nxt & ~PSL_USER_MASK)
				| (merge(psl_r, I_WB_DAT, I_WB_SEL) & PSL_USER_MASK);
			if (priv_ok)
				psl_nxt = (psl_nxt & ~PSL_PRIV_MASK)
					| (merge(psl_r, I_WB_DAT, I_WB_SEL) & PSL_PRIV_MASK);
		end
		if (rei_ok)
			psl_nxt = save_psl_r;
		if (exc_take)
		begin
			psl_nxt[PSL_PRV_LO +: 2] = psl_r[PSL_CUR_LO +: 2];
			psl_nxt[PSL_CUR_LO +: 2] = MODE_KERNEL;
		end
		if (irq_take)
		begin
			psl_nxt[PSL_PRV_LO +: 2] = psl_r[PSL_CUR_LO +: 2];
			psl_nxt[PSL_CUR_LO +: 2] = MODE_KERNEL;
			psl_nxt[PSL_IPL_LO +: 5] = pick_level;
			psl_nxt[PSL_SYSCTX]      = 1'b1;
		end
		if (ctx_load_ok)
			psl_nxt = ctx_mem[slot_r][CTX_PSL] & (PSL_USER_MASK | PSL_PRIV_MASK);
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
			psl_r <= PSL_RESET;
		else if (I_CE)
			psl_r <= psl_nxt;
	end

	// new events are ORed after the clear so a same-cycle event survives
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
			exc_pend_r <= '0;
		else if (I_CE)
			exc_pend_r <= (exc_pend_r & ~exc_clr) | exc_new;
	end

	// dispatch record and captured state
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
		begin
			O_DISP_VALID <= 1'b0;
			O_DISP       <= '0;
			save_pc_r    <= '0;
			save_psl_r   <= '0;
		end
		else if (I_CE)
		begin
			O_DISP_VALID <= irq_take | exc_take;
			if (irq_take)
			begin
				O_DISP     <= '{1'b1, VEC_INT_BASE + {3'h0, pick_level}, pick_level, I_PC,
					psl_r};
				save_pc_r  <= I_PC;
				save_psl_r <= psl_r;
			end
			else if (exc_take)
			begin
				O_DISP     <= '{1'b0, VEC_EXC_BASE + {5'h00, first_set(exc_pend_r)},
					5'h00, I_PC, psl_r};
				save_pc_r  <= I_PC;
				save_psl_r <= psl_r;
			end
		end
	end

	// hardware context store, whole context per single request
	always_ff @(posedge I_SYS_CLK)
	begin
		if (I_CE && ctx_save_ok)
		begin
			ctx_mem[slot_r][CTX_PSL] <= psl_r;
			ctx_mem[slot_r][CTX_PC]  <= I_PC;
			ctx_mem[slot_r][CTX_SP]  <= I_SP;
			ctx_mem[slot_r][CTX_FP]  <= fp_r;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
		begin
			O_CTX_VALID <= 1'b0;
			O_CTX_PC    <= '0;
			O_CTX_SP    <= '0;
			O_HALTED    <= 1'b0;
		end
		else if (I_CE)
		begin
			O_CTX_VALID <= ctx_load_ok;
			if (ctx_load_ok)
			begin
				O_CTX_PC <= ctx_mem[slot_r][CTX_PC];
				O_CTX_SP <= ctx_mem[slot_r][CTX_SP];
			end
			if (I_HALT_REQ && priv_ok)
				O_HALTED <= 1'b1;
		end
	end

	// frame chain: the old frame pointer is written into the new frame
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
		begin
			fp_r         <= '0;
			O_FRAME_WR   <= 1'b0;
			O_FRAME_ADDR <= '0;
			O_FRAME_DATA <= '0;
		end
		else if (I_CE)
		begin
			O_FRAME_WR <= I_CALL;
			if (ctx_load_ok)
				fp_r <= ctx_mem[slot_r][CTX_FP];
			else if (I_CALL)
			begin
				O_FRAME_ADDR <= I_SP - FRAME_WORD;
				O_FRAME_DATA <= fp_r;
				fp_r         <= I_SP - FRAME_WORD;
			end
			else if (I_RET)
				fp_r <= I_RET_FP;
		end
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
		begin
			O_RESUME_VALID <= 1'b0;
			O_RESUME_PC    <= '0;
		end
		else if (I_CE)
		begin
			O_RESUME_VALID <= rei_ok;
			if (rei_ok)
				O_RESUME_PC <= save_pc_r;
		end
	end

	// privileged configuration registers; refusal is sticky, set beats clear
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
		begin
			slot_r    <= '0;
			refused_r <= 1'b0;
			for (int i = 0; i < MAP_REGIONS; i++)
				map_r[i] <= '0;
		end
		else if (I_CE)
		begin
			if (wb_wr && I_WB_ADR == A_STATUS && I_WB_SEL[1] && I_WB_DAT[STAT_REFUSED])
				refused_r <= 1'b0;
			if (bus_priv_wr && !priv_ok)
				refused_r <= 1'b1;
			else if (bus_priv_wr)
			begin
				if (I_WB_ADR == A_SLOT && I_WB_SEL[0])
					slot_r <= I_WB_DAT[2:0];
				if (I_WB_ADR[7:4] == A_MAP0[7:4])
					map_r[I_WB_ADR[3:2]] <= merge(map_r[I_WB_ADR[3:2]], I_WB_DAT, I_WB_SEL);
			end
		end
	end

	// one-entry translation buffer in front of the mapping registers
	always_comb
	begin
		tb_pa = map_r[I_VA[31:30]] + {2'b00, I_VA[29:0]};
		if (tb_valid_r && tb_vpage_r == I_VA[31:PAGE_BITS])
			tb_pa = {tb_ppage_r, I_VA[PAGE_BITS-1:0]};
	end

	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
		begin
			tb_valid_r <= 1'b0;
			tb_vpage_r <= '0;
			tb_ppage_r <= '0;
			O_BUS_REQ  <= 1'b0;
			O_BUS_ADDR <= '0;
			O_TB_HIT   <= 1'b0;
		end
		else if (I_CE)
		begin
			O_BUS_REQ <= I_VA_REQ;
			if (I_VA_REQ)
			begin
				O_BUS_ADDR <= tb_pa;
				O_TB_HIT   <= tb_valid_r && tb_vpage_r == I_VA[31:PAGE_BITS];
				tb_valid_r <= 1'b1;
				tb_vpage_r <= I_VA[31:PAGE_BITS];
				tb_ppage_r <= tb_pa[31:PAGE_BITS];
			end
			// a mapping change makes the cached page stale
			if (bus_priv_wr && priv_ok && I_WB_ADR[7:4] == A_MAP0[7:4])
				tb_valid_r <= 1'b0;
		end
	end

	// bus slave: ack one cycle after the strobe, read data registered with it
	always_ff @(posedge I_SYS_CLK)
	begin
		if (!I_RST_N)
		begin
			wb_ack_r <= 1'b0;
			wb_dat_r <= '0;
		end
		else if (I_CE)
		begin
			wb_ack_r <= I_WB_CYC & I_WB_STB & ~wb_ack_r;
			case (I_WB_ADR)
				A_PSL:      wb_dat_r <= psl_r;
				A_STATUS:   wb_dat_r <= {23'h0, refused_r, 3'h0, exc_pend_r};
				A_SLOT:     wb_dat_r <= {29'h0, slot_r};
				A_FRAME:    wb_dat_r <= fp_r;
				A_SAVE_PC:  wb_dat_r <= save_pc_r;
				A_SAVE_PSL: wb_dat_r <= save_psl_r;
				8'h20, 8'h24, 8'h28, 8'h2c:
					wb_dat_r <= map_r[I_WB_ADR[3:2]];
				default:    wb_dat_r <= '0;
			endcase
		end
	end

	assign O_WB_ACK         = wb_ack_r;
	assign O_WB_DAT         = wb_dat_r;
	assign O_PSL            = psl_r;
	assign O_FRAME_LINK_PTR = fp_r;

endmodule // sed_status_dispatch

// ### dv/sed_properties.sv
// concurrent checks on the ports of the status and event dispatch block
`timescale 1ns/10ps
module sed_properties import sed_pkg::*; (
	input wire logic               I_SYS_CLK,
	input wire logic               I_RST_N,
	input wire logic               I_CE,
	input wire logic               I_WB_CYC,
	input wire logic               I_WB_STB,
	input wire logic               I_WB_WE,
	input wire logic               O_WB_ACK,
	input wire logic               I_OP_VALID,
	input wire sed_pkg::sed_op_t   I_OP,
	input wire logic               I_INSN_BOUNDARY,
	input wire logic               I_RESUME_POINT,
	input wire logic [15:0]        I_IRQ_REQ,
	input wire logic               I_CTX_LOAD,
	input wire logic               I_CALL,
	input wire logic [31:0]        I_SP,
	input wire logic [31:0]        O_PSL,
	input wire logic               O_DISP_VALID,
	input wire sed_pkg::sed_disp_t O_DISP,
	input wire logic [31:0]        O_FRAME_LINK_PTR,
	input wire logic               O_FRAME_WR,
	input wire logic [31:0]        O_FRAME_ADDR,
	input wire logic [31:0]        O_FRAME_DATA
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_N);
	logic [31:0] diff;
	logic        sub_ok;
	logic        intr;
	// a bus write or context load in the same cycle may legally overwrite the flags
	assign diff = I_OP.a - I_OP.b;
	assign sub_ok = I_CE && I_OP_VALID && I_OP.kind == SED_K_SUB && !I_CTX_LOAD
		&& !(I_WB_CYC && I_WB_STB && I_WB_WE);
	assign intr = O_DISP_VALID && O_DISP.is_intr;
	a_ack_single: assert property (O_WB_ACK |=> !O_WB_ACK) else $error("ack too long");
	a_ack_answer: assert property ($rose(I_WB_CYC && I_WB_STB) && I_CE |=> O_WB_ACK)
		else $error("ack missing");
	a_ack_cause: assert property (O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB))
		else $error("ack without request");
	a_psl_spare: assert property ((O_PSL & ~(PSL_USER_MASK | PSL_PRIV_MASK)) == 32'h0)
		else $error("spare status bits set");
	a_neg_flag: assert property (sub_ok |=> O_PSL[PSL_N] == $past(diff[31]))
		else $error("negative flag wrong");
	a_zero_flag: assert property (sub_ok |=> O_PSL[PSL_Z] == ($past(diff) == 32'h0))
		else $error("zero flag wrong");
	a_dvz_trap: assert property (I_CE && I_OP_VALID && I_OP.is_div && I_OP.b == 32'h0
		|-> ##[1:4] O_DISP_VALID) else $error("divide by zero not dispatched");
	a_intr_point: assert property (intr |-> $past(I_INSN_BOUNDARY || I_RESUME_POINT))
		else $error("interrupt taken mid instruction");
	a_intr_top: assert property (intr |-> O_DISP.vector == VEC_INT_BASE + {3'h0, O_DISP.level}
		&& ($past(I_IRQ_REQ) >> O_DISP.level) == 16'h1) else $error("interrupt choice wrong");
	a_frame_push: assert property (I_CE && I_CALL && !I_CTX_LOAD |=> O_FRAME_WR
		&& O_FRAME_ADDR == $past(I_SP) - FRAME_WORD && O_FRAME_DATA == $past(O_FRAME_LINK_PTR))
		else $error("call frame link wrong");
endmodule // sed_properties

bind sed_status_dispatch sed_properties sed_properties_i (.I_SYS_CLK(I_SYS_CLK),
	.I_RST_N(I_RST_N), .I_CE(I_CE), .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB),
	.I_WB_WE(I_WB_WE), .O_WB_ACK(O_WB_ACK), .I_OP_VALID(I_OP_VALID), .I_OP(I_OP),
	.I_INSN_BOUNDARY(I_INSN_BOUNDARY), .I_RESUME_POINT(I_RESUME_POINT),
	.I_IRQ_REQ(I_IRQ_REQ), .I_CTX_LOAD(I_CTX_LOAD), .I_CALL(I_CALL), .I_SP(I_SP),
	.O_PSL(O_PSL), .O_DISP_VALID(O_DISP_VALID), .O_DISP(O_DISP),
	.O_FRAME_LINK_PTR(O_FRAME_LINK_PTR), .O_FRAME_WR(O_FRAME_WR),
	.O_FRAME_ADDR(O_FRAME_ADDR), .O_FRAME_DATA(O_FRAME_DATA));

// ### dv/tb_top.sv
// self-checking bench for the status and event dispatch block
`timescale 1ns/10ps
module tb_top;
	import sed_pkg::*;
	logic        clk = 1'h0, rst_n = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, opv = 1'h0;
	logic        bnd = 1'h0, rsp = 1'h0, call = 1'h0, vreq = 1'h0, ack, dv, fwr, breq, hit;
	logic        ce = 1'h1, sv = 1'h0, ld = 1'h0, hlt = 1'h0, cv, hd, rv;
	logic [3:0]  sel = 4'hf;
	logic [7:0]  adr = 8'h0;
	logic [15:0] irq = 16'h0;
	logic [31:0] wd = 32'h0, pc = 32'h0, sp = 32'h0, va = 32'h0, rd, q, processor_status_longword, fad, fdat, fp;
	logic [31:0] badr, x, y, e, cpc, csp, rpc;
	sed_op_t     opd = '0;
	sed_disp_t   disp;
	sed_kind_t   ks[3] = '{SED_K_INT, SED_K_FLT, SED_K_DEC};
	int          fail_count = 0, checked = 0, n, lv;

	sed_status_dispatch sed_status_dispatch_i (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CE(ce),
		.I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
		.I_WB_DAT(wd), .O_WB_DAT(rd), .O_WB_ACK(ack), .I_OP_VALID(opv), .I_OP(opd),
		.I_INSN_BOUNDARY(bnd), .I_RESUME_POINT(rsp), .I_PC(pc), .I_SP(sp), .I_IRQ_REQ(irq),
		.I_HALT_REQ(hlt), .I_CTX_SAVE(sv), .I_CTX_LOAD(ld), .I_CALL(call), .I_RET(1'h0),
		.I_RET_FP(pc), .I_VA_REQ(vreq), .I_VA(va), .O_PSL(processor_status_longword), .O_DISP_VALID(dv),
		.O_DISP(disp), .O_HALTED(hd), .O_CTX_VALID(cv), .O_CTX_PC(cpc), .O_CTX_SP(csp),
		.O_FRAME_LINK_PTR(fp), .O_FRAME_WR(fwr), .O_FRAME_ADDR(fad), .O_FRAME_DATA(fdat),
		.O_RESUME_VALID(rv), .O_RESUME_PC(rpc), .O_BUS_REQ(breq), .O_BUS_ADDR(badr),
		.O_TB_HIT(hit));

	initial
	forever #50 clk = ~clk;

	task automatic test_done;
		$display("checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic hang;
		fail_count++;
		$display("Error at %0t: wait ran out", $time);
		test_done;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] w);
		checked++;
		if (g !== w)
		begin
			fail_count++;
			$display("Error at %0t: got %h, want %h", $time, g, w);
		end
	endtask

	// classic single cycle; request held until ack is sampled at an edge
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do
			@(posedge clk);
		while (ack !== 1'h1 && ++n < 20);
		if (ack !== 1'h1)
			hang;
		q = rd;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
	endtask

	task automatic op(input sed_kind_t k, input logic dz, input logic [31:0] a, b, r,
		input logic ov, input logic un);
		@(posedge clk);
		opv <= 1'h1;
		opd <= '{k, dz, a, b, r, ov, un};
		@(posedge clk);
		opv <= 1'h0;
	endtask

	task automatic wdisp(input logic [7:0] v);
		n = 0;
		do
			@(posedge clk);
		while (dv !== 1'h1 && ++n < 8);
		if (dv !== 1'h1)
			hang;
		chk({24'h0, disp.vector}, {24'h0, v});
	endtask

	task automatic quiet;
		repeat (3)
		begin
			@(posedge clk);
			chk({31'h0, dv}, 32'h0);
		end
	endtask

	function automatic logic [3:0] cc_sub(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] d;
		d = a - b;
		return {d[31], d == 32'h0, (a[31] ^ b[31]) & (a[31] ^ d[31]), a < b};
	endfunction

	function automatic int top(input logic [15:0] r);
		top = 0;
		for (int i = 1; i < 16; i++)
			if (r[i])
				top = i;
	endfunction

	initial
	begin
		repeat (20000) @(posedge clk);
		hang;
	end

	initial
	begin
		void'($urandom(32'he7dd4bfb));
		pc = $urandom;
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		chk(processor_status_longword, PSL_RESET);
		wb(1'h0, A_PSL, 32'h0);
		chk(q, PSL_RESET);
		wb(1'h0, 8'hfc, 32'h0);
		chk(q, 32'h0);
		for (int i = 0; i < 24; i++)
		begin
			x = (i == 2) ? 32'h0 : ((i == 3) ? 32'h8000_0000 : $urandom);
			y = (i < 2) ? x : ((i < 4) ? 32'h1 : $urandom);
			op(SED_K_SUB, 1'h0, x, y, x - y, 1'h0, 1'h0);
			@(posedge clk);
			chk(processor_status_longword[3:0], cc_sub(x, y));
		end
		// a low clock enable must swallow an operation whole
		ce <= 1'h0;
		op(SED_K_SUB, 1'h0, 32'h0, 32'h0, 32'h0, 1'h0, 1'h0);
		ce <= 1'h1;
		@(posedge clk);
		chk(processor_status_longword[3:0], cc_sub(x, y));
		// enables still clear: only the condition codes move
		for (int i = 0; i < 3; i++)
		begin
			op(ks[i], 1'h0, 32'h0, 32'h3, 32'h0, 1'h1, 1'h1);
			@(posedge clk);
			chk(processor_status_longword[3:0], 32'h6);
			wb(1'h0, A_STATUS, 32'h0);
			chk(q[4:0], 32'h0);
		end
		wb(1'h1, A_PSL, 32'h001f_0060);
		for (int i = 0; i < 3; i++)
		begin
			op(ks[i], 1'h0, 32'h0, 32'h3, 32'h1, 1'h1, 1'h0);
			wdisp(VEC_EXC_BASE + 8'h1);
			op(ks[i], 1'h1, 32'h5, 32'h0, 32'h1, 1'h0, 1'h0);
			wdisp(VEC_EXC_BASE + 8'h2);
			chk(disp.saved_pc, pc);
		end
		op(SED_K_FLT, 1'h0, 32'h0, 32'h3, 32'h1, 1'h0, 1'h1);
		wdisp(VEC_EXC_BASE + 8'h3);
		wb(1'h1, A_PSL, 32'h001f_0010);
		@(posedge clk);
		bnd <= 1'h1;
		@(posedge clk);
		bnd <= 1'h0;
		wdisp(VEC_EXC_BASE);
		wb(1'h1, A_PSL, 32'h0005_0000);
		for (int i = 0; i < 6; i++)
		begin
			@(posedge clk);
			irq <= (i == 0) ? 16'h0021 : (16'($urandom) | (16'h0040 << i));
			quiet();
			bnd <= i[0];
			rsp <= !i[0];
			@(posedge clk);
			bnd <= 1'h0;
			rsp <= 1'h0;
			lv = top(irq);
			if (i == 0)
				quiet();
			else
			begin
				wdisp(VEC_INT_BASE + 8'(lv));
				@(posedge clk);
				chk(processor_status_longword & 32'h041f_0000, 32'h0400_0000 | (32'(lv) << 16));
			end
			wb(1'h1, A_PSL, 32'h0005_0000);
		end
		// exception and interrupt raised at the same edge
		@(posedge clk);
		irq <= 16'h0200;
		bnd <= 1'h1;
		opv <= 1'h1;
		opd <= '{SED_K_INT, 1'h1, 32'h7, 32'h0, 32'h0, 1'h0, 1'h0};
		@(posedge clk);
		bnd <= 1'h0;
		opv <= 1'h0;
		wdisp(VEC_INT_BASE + 8'h9);
		wdisp(VEC_EXC_BASE + 8'h2);
		irq <= 16'h0;
		e = 32'h0;
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			sp <= $urandom & 32'hffff_fffc;
			call <= 1'h1;
			@(posedge clk);
			call <= 1'h0;
			@(posedge clk);
			chk({31'h0, fwr}, 32'h1);
			chk(fad, sp - FRAME_WORD);
			chk(fdat, e);
			e = sp - FRAME_WORD;
		end
		wb(1'h0, A_FRAME, 32'h0);
		chk(q, e);
		for (int i = 0; i < 2; i++)
		begin
			@(posedge clk);
			va <= (i == 0) ? $urandom : va ^ 32'h1f;
			vreq <= 1'h1;
			@(posedge clk);
			vreq <= 1'h0;
			@(posedge clk);
			chk({breq, hit}, {1'h1, i[0]});
			chk(badr, {2'h0, va[29:0]});
		end
		// save a known context, disturb it, then load it back
		wb(1'h1, A_PSL, 32'h001f_0005);
		wb(1'h1, A_SLOT, 32'h3);
		@(posedge clk);
		sv <= 1'h1;
		@(posedge clk);
		sv <= 1'h0;
		x = sp;
		y = pc;
		sp <= sp ^ 32'h100;
		pc <= pc + 32'h4;
		call <= 1'h1;
		@(posedge clk);
		call <= 1'h0;
		wb(1'h1, A_PSL, 32'h001e_0000);
		@(posedge clk);
		ld <= 1'h1;
		@(posedge clk);
		ld <= 1'h0;
		@(posedge clk);
		chk({31'h0, cv}, 32'h1);
		chk(cpc, y);
		chk(csp, x);
		chk(processor_status_longword, 32'h001f_0005);
		chk(fp, e);
		hlt <= 1'h1;
		@(posedge clk);
		hlt <= 1'h0;
		@(posedge clk);
		chk({31'h0, hd}, 32'h1);
		wb(1'h1, A_PSL, 32'h0300_0000);
		wb(1'h1, A_SLOT, 32'h5);
		wb(1'h0, A_STATUS, 32'h0);
		chk(q[8], 32'h1);
		wb(1'h1, A_PSL, 32'h0000_007f);
		wb(1'h0, A_PSL, 32'h0);
		chk(q, 32'h0300_007f);
		// halt from user mode traps, the handler then resumes the user state
		@(posedge clk);
		hlt <= 1'h1;
		@(posedge clk);
		hlt <= 1'h0;
		wdisp(VEC_EXC_BASE + 8'h4);
		wb(1'h1, A_CTRL, 32'h1);
		@(posedge clk);
		chk({31'h0, rv}, 32'h1);
		chk(rpc, pc);
		chk(processor_status_longword, 32'h0300_007f);
		test_done;
	end
endmodule // tb_top
